// *** logic/dio_pkg.sv ***
package dio_pkg;
  // ----------------------------------------------------------------
  // channel counts and widths
  // ----------------------------------------------------------------
  localparam int DIO_CH = 32;
  localparam int DIO_ADDR_W = 8;
  localparam int DIO_FILT_W = 8;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [DIO_ADDR_W-1:0] DIO_REG_IN = 8'h00;
  localparam logic [DIO_ADDR_W-1:0] DIO_REG_OUT = 8'h04;
  localparam logic [DIO_ADDR_W-1:0] DIO_REG_IEN = 8'h08;
  localparam logic [DIO_ADDR_W-1:0] DIO_REG_EDGE = 8'h0C;
  localparam logic [DIO_ADDR_W-1:0] DIO_REG_PEND = 8'h10;
  localparam logic [DIO_ADDR_W-1:0] DIO_REG_FILT = 8'h14;

  // ----------------------------------------------------------------
  // values after reset, and the value read at unmapped addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] DIO_OUT_RST = 32'h0000_0000;
  localparam logic [31:0] DIO_IEN_RST = 32'h0000_0000;
  localparam logic [31:0] DIO_EDGE_RST = 32'h0000_0000;
  localparam logic [31:0] DIO_PEND_RST = 32'h0000_0000;
  localparam logic [DIO_FILT_W-1:0] DIO_FILT_RST = 8'h10;
  localparam logic [31:0] DIO_UNMAPPED = 32'h0000_0000;
endpackage

// *** logic/dio_filt_if.sv ***
`timescale 1ns/1ns
interface dio_filt_if #(
  parameter int N = 32,
  parameter int W = 8
);
  logic [N-1:0] raw;
  logic [W-1:0] setting;
  logic [N-1:0] clean;

  modport core (output raw, output setting, input clean);
  modport filt (input raw, input setting, output clean);
endinterface

// *** logic/dio_filter.sv ***
`timescale 1ns/1ns
module dio_filter #(
  parameter int N = 32,
  parameter int W = 8
) (
  input wire logic clock,  // system clock
  input wire logic rst,    // async reset, active high
  dio_filt_if.filt fi      // raw samples in, filtered levels out
);
  import dio_pkg::*;

  // ----------------------------------------------------------------
  // per-channel stability counters
  // ----------------------------------------------------------------
  // a level is taken only after it has differed for setting+1 cycles;
  // any bounce back to the old level restarts the count
  logic [N-1:0] clean;
  assign fi.clean = clean;

  for (genvar i = 0; i < N; i++) begin : g_ch
    logic [W-1:0] cnt;
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        cnt <= '0;
        clean[i] <= 1'b0;
      end else if (fi.raw[i] == clean[i]) begin
        cnt <= '0;
      end else if (cnt >= fi.setting) begin
        cnt <= '0;
        clean[i] <= fi.raw[i];
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // zero filter setting passes at once; filtered level held while input agrees
  a_filt_bypass: assert property (@(posedge clock) disable iff (rst)
    (fi.setting == '0 && fi.raw != clean) |=> (clean == $past(fi.raw)))
    else $error("zero filter setting did not pass input in one cycle");
  a_filt_hold: assert property (@(posedge clock) disable iff (rst)
    (fi.raw == clean) |=> $stable(clean))
    else $error("filtered level moved while input agreed with it");
endmodule

// *** logic/dio_core.sv ***
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
// Function
// - thirty-two input channels, each usable as an interrupt source
// - per-bit interrupt enable set by software
// - per-bit software choice of interrupting edge
// - logical rising edge is pin high-to-low, falling is low-to-high
// - all input interrupt conditions merge into one request output
// - software-configured noise and chatter filter on every input
// - inputs read in negative logic: low pin reads as one
// - thirty-two outputs in negative logic: one pulls line low
// - data zero is high level, data one is low level
module dio_core #(
  parameter int N = dio_pkg::DIO_CH,     // channel count
  parameter int FW = dio_pkg::DIO_FILT_W // filter setting width
) (
  input wire logic clock,                                      // 250 MHz clock
  input wire logic rst,                                        // async reset
  input wire logic [dio_pkg::DIO_ADDR_W-1:0] avs_address,      // byte address
  input wire logic avs_read,                                   // read request
  input wire logic avs_write,                                  // write request
  input wire logic [31:0] avs_writedata,                       // write data
  input wire logic [3:0] avs_byteenable,                       // byte lanes
  output logic [31:0] avs_readdata,                            // read data
  output logic avs_waitrequest,                                // stall
  input wire logic [N-1:0] in_pin_n,                           // input pins
  output logic [N-1:0] out_pin_n,                              // output pins
  output logic shared_interrupt_request                        // merged request
);
  import dio_pkg::*;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait state: the access completes on the second edge, which
  // gives readdata a full cycle from the decode
  logic ack;
  logic req;
  logic take;
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign take = req & ack;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{be[b]}};
    end
    return m;
  endfunction

  logic [31:0] wmask;
  logic wr_out, wr_ien, wr_edge, wr_pend, wr_filt;
  assign wmask = lane_mask(avs_byteenable);
  assign wr_out = take & avs_write & (avs_address == DIO_REG_OUT);
  assign wr_ien = take & avs_write & (avs_address == DIO_REG_IEN);
  assign wr_edge = take & avs_write & (avs_address == DIO_REG_EDGE);
  assign wr_pend = take & avs_write & (avs_address == DIO_REG_PEND);
  assign wr_filt = take & avs_write & (avs_address == DIO_REG_FILT);

  // ----------------------------------------------------------------
  // input path
  // ----------------------------------------------------------------
  // all inputs sampled
  logic [N-1:0] sync1;
  logic [N-1:0] sync2;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= in_pin_n;
      sync2 <= sync1;
    end
  end

  logic [FW-1:0] filt_set;
  dio_filt_if #(.N(N), .W(FW)) fif ();
  assign fif.raw = ~sync2;
  assign fif.setting = filt_set;

  dio_filter #(.N(N), .W(FW)) u_filter (
    .clock(clock),
    .rst(rst),
    .fi(fif.filt)
  );

  logic [N-1:0] in_logic;
  logic [N-1:0] in_prev;
  assign in_logic = fif.clean;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_prev <= '0;
    end else begin
      in_prev <= in_logic;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [N-1:0] out_data;
  logic [N-1:0] irq_en;
  logic [N-1:0] edge_rise;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_data <= DIO_OUT_RST[N-1:0];
      irq_en <= DIO_IEN_RST[N-1:0];
      edge_rise <= DIO_EDGE_RST[N-1:0];
      filt_set <= DIO_FILT_RST;
    end else begin
      if (wr_out) out_data <= (out_data & ~wmask[N-1:0]) | (avs_writedata[N-1:0] & wmask[N-1:0]);
      if (wr_ien) irq_en <= (irq_en & ~wmask[N-1:0]) | (avs_writedata[N-1:0] & wmask[N-1:0]);
      if (wr_edge) begin
        edge_rise <= (edge_rise & ~wmask[N-1:0]) | (avs_writedata[N-1:0] & wmask[N-1:0]);
      end
      if (wr_filt) begin
        filt_set <= (filt_set & ~wmask[FW-1:0]) | (avs_writedata[FW-1:0] & wmask[FW-1:0]);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_pin_n <= ~DIO_OUT_RST[N-1:0];
    end else if (wr_out) begin
      out_pin_n <= ~((out_data & ~wmask[N-1:0]) | (avs_writedata[N-1:0] & wmask[N-1:0]));
    end
  end

  // ----------------------------------------------------------------
  // edge detect and pending flags
  // ----------------------------------------------------------------
  // logical rise is a high-to-low pin transition
  logic [N-1:0] ev_rise;
  logic [N-1:0] ev_fall;
  logic [N-1:0] ev;
  assign ev_rise = in_logic & ~in_prev;
  assign ev_fall = ~in_logic & in_prev;
  // enable and edge choice per bit
  assign ev = irq_en & ((edge_rise & ev_rise) | (~edge_rise & ev_fall));

  logic [N-1:0] pending;
  logic [N-1:0] pend_clr;
  assign pend_clr = wr_pend ? (avs_writedata[N-1:0] & wmask[N-1:0]) : '0;

  // set wins over a same-cycle clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pending <= DIO_PEND_RST[N-1:0];
    end else begin
      pending <= (pending & ~pend_clr) | ev;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shared_interrupt_request <= 1'b0;
    end else begin
      shared_interrupt_request <= |pending;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unaligned or unmapped addresses read zero and ignore writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read & ~ack) begin
      unique case (avs_address)
        DIO_REG_IN: avs_readdata <= 32'(in_logic);
        DIO_REG_OUT: avs_readdata <= 32'(out_data);
        DIO_REG_IEN: avs_readdata <= 32'(irq_en);
        DIO_REG_EDGE: avs_readdata <= 32'(edge_rise);
        DIO_REG_PEND: avs_readdata <= 32'(pending);
        DIO_REG_FILT: avs_readdata <= 32'(filt_set);
        default: avs_readdata <= DIO_UNMAPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_req_start;
    req && avs_waitrequest;
  endsequence
  sequence s_req_done;
    !avs_waitrequest && req;
  endsequence

  a_bus_one_wait: assert property (@(posedge clock) disable iff (rst)
    s_req_start ##1 req |-> s_req_done)
    else $error("access did not complete after one wait state");

  a_out_write_neg: assert property (@(posedge clock) disable iff (rst)
    (wr_out && avs_byteenable == 4'hF) |=> (out_pin_n == ~$past(avs_writedata[N-1:0])))
    else $error("output pins do not show inverted written data");

  a_in_read_neg: assert property (@(posedge clock) disable iff (rst)
    (avs_read && !ack && avs_address == DIO_REG_IN) |=>
      (avs_readdata[N-1:0] == $past(~fif.clean ^ '1)))
    else $error("input read does not return logical input levels");

  a_rise_sets_pend: assert property (@(posedge clock) disable iff (rst)
    (|(irq_en & edge_rise & ev_rise)) |=>
      ((pending & $past(irq_en & edge_rise & ev_rise)) == $past(irq_en & edge_rise & ev_rise)))
    else $error("selected rising edge did not set pending");

  a_fall_sets_pend: assert property (@(posedge clock) disable iff (rst)
    (|(irq_en & ~edge_rise & ev_fall)) |=>
      ((pending & $past(irq_en & ~edge_rise & ev_fall)) == $past(irq_en & ~edge_rise & ev_fall)))
    else $error("selected falling edge did not set pending");

  a_masked_no_set: assert property (@(posedge clock) disable iff (rst)
    1'b1 |=> ((pending & ~$past(pending) & ~$past(irq_en)) == '0))
    else $error("disabled channel raised a pending flag");

  a_clear_w1c: assert property (@(posedge clock) disable iff (rst)
    (wr_pend && ev == '0) |=> ((pending & $past(pend_clr)) == '0))
    else $error("pending flag survived a clear");

  a_irq_merge: assert property (@(posedge clock) disable iff (rst)
    (|pending) |=> shared_interrupt_request ##0 (|pending) [*1] or
      (!(|pending) ##1 !shared_interrupt_request))
    else $error("shared request does not follow pending flags");
endmodule

// *** tb/dio_field.sv ***
`timescale 1ns/1ns
module dio_field (
  input wire logic clock,           // system clock
  input wire logic [31:0] level_n,  // wanted pin levels
  input wire logic glitch_en,       // bounce one channel
  input wire logic [4:0] glitch_ch, // channel that bounces
  input wire logic [31:0] out_pin_n, // device output pins
  output logic [31:0] in_pin_n,     // device input pins
  output logic [31:0] load_on       // loads energised
);
  logic tog = 1'b0;
  // a contact bouncing every cycle must never get through a nonzero filter setting
  always @(posedge clock) begin
    tog <= glitch_en ? ~tog : 1'b0;
  end
  always_comb begin
    in_pin_n = level_n;
    in_pin_n[glitch_ch] = level_n[glitch_ch] ^ tog;
  end
  // open collector: a low pin lets current flow through the load
  assign load_on = ~out_pin_n;
endmodule

// *** tb/isolated_dio_interrupt_filter_tb.sv ***
`timescale 1ns/1ns
module isolated_dio_interrupt_filter_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] in_pin_n;
  logic [31:0] out_pin_n;
  logic [31:0] load_on;
  logic [31:0] level_n = 32'hFFFF_FFFF;
  logic glitch_en = 1'b0;
  logic irq;
  logic [31:0] q;
  int bad_count = 0;
  int num_checks = 0;

  always #2 clock = ~clock;

  dio_core u_dio_core (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .in_pin_n(in_pin_n), .out_pin_n(out_pin_n),
    .shared_interrupt_request(irq));
  dio_field u_dio_field (.clock(clock), .level_n(level_n), .glitch_en(glitch_en),
    .glitch_ch(5'h08), .out_pin_n(out_pin_n), .in_pin_n(in_pin_n), .load_on(load_on));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clock);
  endtask

  // holds the request until waitrequest is sampled low, no fixed latency assumed
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    // a slave that never answers ends the run here instead of faking a transfer
    if (n >= 20) begin
      chk("bus answer", 32'h1, 32'h0);
      end_of_test();
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(nm, exp, q);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("out pins", 32'hFFFF_FFFF, out_pin_n);
    chk("irq", 32'h0, {31'h0, irq});
    rd("out", 8'h04, 32'h0000_0000);
    rd("ien", 8'h08, 32'h0000_0000);
    rd("edge", 8'h0C, 32'h0000_0000);
    rd("pend", 8'h10, 32'h0000_0000);
    rd("filt", 8'h14, 32'h0000_0010);
    bus(1'b1, 8'h18, 32'hFFFF_FFFF, 4'hF);
    rd("unmapped", 8'h18, 32'h0000_0000);
  endtask

  task automatic t_out();
    bus(1'b1, 8'h04, 32'h0000_00A5, 4'hF);
    wt(1);
    chk("out pins", 32'hFFFF_FF5A, out_pin_n);
    chk("loads", 32'h0000_00A5, load_on);
    bus(1'b1, 8'h04, 32'hFFFF_FFFF, 4'b0010);
    rd("out lane", 8'h04, 32'h0000_FFA5);
    wt(1);
    chk("out pins lane", 32'hFFFF_005A, out_pin_n);
  endtask

  // bit0 rising, bit1 falling, bit2 disabled, bit8 bounces
  task automatic t_irq();
    bus(1'b1, 8'h14, 32'h0000_0003, 4'hF);
    bus(1'b1, 8'h08, 32'h0000_0003, 4'hF);
    bus(1'b1, 8'h0C, 32'h0000_0001, 4'hF);
    level_n <= 32'hFFFF_FFF8;
    glitch_en <= 1'b1;
    wt(14);
    rd("in", 8'h00, 32'h0000_0007);
    rd("pend rise", 8'h10, 32'h0000_0001);
    chk("irq set", 32'h1, {31'h0, irq});
    level_n <= 32'hFFFF_FFFF;
    glitch_en <= 1'b0;
    wt(14);
    rd("in back", 8'h00, 32'h0000_0000);
    rd("pend fall", 8'h10, 32'h0000_0003);
    bus(1'b1, 8'h10, 32'h0000_0001, 4'hF);
    rd("pend clr0", 8'h10, 32'h0000_0002);
    chk("irq held", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h10, 32'h0000_0002, 4'hF);
    wt(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    rd("pend off", 8'h10, 32'h0000_0000);
  endtask

  // zero setting: a level is taken on the first cycle it reaches the filter,
  // so a read decoded four edges after the pin change already shows it
  task automatic t_fast();
    bus(1'b1, 8'h14, 32'h0000_0000, 4'hF);
    level_n <= 32'hFFFF_FFEF;
    wt(2);
    rd("in fast", 8'h00, 32'h0000_0010);
    level_n <= 32'hFFFF_FFFF;
    wt(2);
    rd("in fast back", 8'h00, 32'h0000_0000);
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_out();
    t_irq();
    t_fast();
    end_of_test();
  end

  // all scenarios need well under 300 cycles
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    end_of_test();
  end
endmodule
